/* File: src/srw_consts.vh */
// Summary of operation
// - each trigger drives reset low 200ms
// - reset low while brownout or button low
// - hold 200ms after any release cause
// - button low asserts reset plus hold
// - ignore button glitches, honour 1us lows
// - no heartbeat edge in 1.6s resets
// - timeout within 1.12s to 2.40s window
// - heartbeat edges and reset clear timer
// - accept heartbeat pulses of 50ns
// - timer held zero during reset
// - floating heartbeat disables watchdog
// - self-kick low 7/8, high 1/8
// - self-kick edges clear timer at 1.4s and 1.6s of each 1.6s period
// - brownout restarts the hold timer
// - high reset is inverse of low
`ifndef SRW_CONSTS_VH
`define SRW_CONSTS_VH
`define SRW_CLK_HZ          100000000
`define SRW_HOLD_MS         200
// counts below are the 100 MHz clock times each interval, the filter count one past the 100ns glitch, sized to the counters
`define SRW_HOLD_CYC        28'd20000000
`define SRW_KICK_MS         1600
`define SRW_KICK_CYC        28'd160000000
`define SRW_SELF_NUM        7
`define SRW_SELF_DEN        8
`define SRW_SELF_LOW_CYC    28'd140000000
`define SRW_GLITCH_NS       100
`define SRW_BTN_MIN_NS      1000
`define SRW_CLK_NS          10
`define SRW_FILT_CYC        5'd11
`define SRW_CNT_W           28
`define SRW_FILT_W          5
`endif

/* File: src/srw_filter.v */
`timescale 1ns/1ps
`include "srw_consts.vh"
module srw_filter
(
    input  wire sys_clk_in,
    input  wire rst_b_in,
    input  wire raw_in,
    output reg  clean_out
);
    reg                   sync_a;
    reg                   sync_b;
    reg [`SRW_FILT_W-1:0] run;
    localparam [`SRW_FILT_W-1:0] FILT_END = `SRW_FILT_CYC;
    // level must stay stable beyond glitch width before it is believed
    always @(posedge sys_clk_in or negedge rst_b_in)
        if (!rst_b_in)
        begin
            sync_a    <= 1'b1;
            sync_b    <= 1'b1;
            run       <= {`SRW_FILT_W{1'b0}};
            clean_out <= 1'b1;
        end
        else
        begin
            sync_a <= raw_in;
            sync_b <= sync_a;
            if (sync_b == clean_out)
                run <= {`SRW_FILT_W{1'b0}};
            else if (run == FILT_END)
            begin
                clean_out <= sync_b;
                run       <= {`SRW_FILT_W{1'b0}};
            end
            else
                run <= run + 1'b1;
        end
endmodule // srw_filter

/* File: src/srw_top.v */
`timescale 1ns/1ps
`include "srw_consts.vh"
module srw_top
#(
    parameter [`SRW_CNT_W-1:0] HOLD_CYC     = `SRW_HOLD_CYC,
    parameter [`SRW_CNT_W-1:0] KICK_CYC     = `SRW_KICK_CYC,
    parameter [`SRW_CNT_W-1:0] SELF_LOW_CYC = `SRW_SELF_LOW_CYC
)
(
    input  wire sys_clk_in,
    input  wire rst_b_in,
    input  wire supply_low_in,
    input  wire push_button_clear_n,
    input  wire heartbeat_in,
    input  wire heartbeat_float_in,
    output wire heartbeat_out,
    output wire heartbeat_oe_out,
    output reg  reset_n_out,
    output wire reset_out
);
    localparam [2:0]            ST_FORCE = 3'b001;
    localparam [2:0]            ST_HOLD  = 3'b010;
    localparam [2:0]            ST_RUN   = 3'b100;
    localparam [`SRW_CNT_W-1:0] CNT_ZERO = {`SRW_CNT_W{1'b0}};

    reg                  sl_a;
    reg                  sl_b;
    reg                  fl_a;
    reg                  fl_b;
    reg                  hb_a;
    reg                  hb_b;
    reg                  hb_c;
    wire                 btn_clean;
    reg [2:0]            state;
    reg [2:0]            next_state;
    reg [`SRW_CNT_W-1:0] hold;
    reg [`SRW_CNT_W-1:0] next_hold;
    reg [`SRW_CNT_W-1:0] wd;
    reg [`SRW_CNT_W-1:0] next_wd;
    reg [`SRW_CNT_W-1:0] selfc;
    reg [`SRW_CNT_W-1:0] next_selfc;
    reg                  expire;
    reg                  next_expire;
    reg                  kick_lvl;
    reg                  next_kick_lvl;
    reg                  kick_oe;
    wire                 force_rst;
    wire                 hb_edge;

    // last count of a period that starts at zero
    function at_end;
        input [`SRW_CNT_W-1:0] cnt;
        input [`SRW_CNT_W-1:0] lim;
        begin
            at_end = (cnt == lim - 1'b1);
        end
    endfunction

    srw_filter u_filt
    (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .raw_in     (push_button_clear_n),
        .clean_out  (btn_clean)
    );

    always @(posedge sys_clk_in or negedge rst_b_in)
        if (!rst_b_in)
        begin
            sl_a <= 1'b1;
            sl_b <= 1'b1;
            fl_a <= 1'b0;
            fl_b <= 1'b0;
            hb_a <= 1'b0;
            hb_b <= 1'b0;
            hb_c <= 1'b0;
        end
        else
        begin
            sl_a <= supply_low_in;
            sl_b <= sl_a;
            fl_a <= heartbeat_float_in;
            fl_b <= fl_a;
            hb_a <= heartbeat_in;
            hb_b <= hb_a;
            hb_c <= hb_b;
        end

    // 50ns pulse spans several 10ns samples, so two flops still catch it
    assign hb_edge   = hb_b ^ hb_c;
    assign force_rst = sl_b | ~btn_clean | expire;

    // hold reloads every cycle a cause is active, so it counts from the last one
    always @*
    begin
        next_state = state;
        next_hold  = hold;
        case (state)
            ST_FORCE:
            begin
                next_hold = HOLD_CYC;
                if (!force_rst)
                begin
                    next_hold  = HOLD_CYC - 1'b1;
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                if (force_rst)
                begin
                    next_hold  = HOLD_CYC;
                    next_state = ST_FORCE;
                end
                else if (hold == CNT_ZERO)
                    next_state = ST_RUN;
                else
                    next_hold = hold - 1'b1;
            end
            ST_RUN:
            begin
                if (force_rst)
                begin
                    next_hold  = HOLD_CYC;
                    next_state = ST_FORCE;
                end
            end
            default:
            begin
                next_hold  = HOLD_CYC;
                next_state = ST_FORCE;
            end
        endcase
    end

    // watchdog is held at zero in reset and starts at once on release
    always @*
    begin
        next_wd     = wd + 1'b1;
        next_expire = 1'b0;
        if (!reset_n_out || hb_edge)
            next_wd = CNT_ZERO;
        else if (fl_b)
            next_wd = CNT_ZERO;
        else if (at_end(wd, KICK_CYC))
        begin
            next_expire = 1'b1;
            next_wd     = CNT_ZERO;
        end
    end

    // self-kick driver; a floating pin follows it, so the watchdog sees edges
    always @*
    begin
        next_selfc = selfc + 1'b1;
        if (!reset_n_out || at_end(selfc, KICK_CYC))
            next_selfc = CNT_ZERO;
        next_kick_lvl = (next_selfc >= SELF_LOW_CYC);
    end

    always @(posedge sys_clk_in or negedge rst_b_in)
        if (!rst_b_in)
        begin
            state       <= ST_HOLD;
            hold        <= HOLD_CYC;
            reset_n_out <= 1'b0;
            wd          <= CNT_ZERO;
            expire      <= 1'b0;
            selfc       <= CNT_ZERO;
            kick_lvl    <= 1'b0;
            kick_oe     <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            hold        <= next_hold;
            reset_n_out <= (next_state == ST_RUN);
            wd          <= next_wd;
            expire      <= next_expire;
            selfc       <= next_selfc;
            kick_lvl    <= next_kick_lvl;
            // weak driver only matters while nothing else drives the pin
            kick_oe     <= fl_b;
        end

    assign reset_out        = ~reset_n_out;
    assign heartbeat_out    = kick_lvl;
    assign heartbeat_oe_out = kick_oe;
endmodule // srw_top

/* File: sim/srw_chk.sv */
`timescale 1ns/1ps
module srw_chk #(parameter H = 200, parameter K = 1600)
(input logic sys_clk_in, rst_b_in, supply_low_in, push_button_clear_n, heartbeat_in,
    heartbeat_float_in, heartbeat_out, heartbeat_oe_out, reset_n_out, reset_out);
// run lengths, no reset: used as bounds, and hi as an exact high time
logic [15:0] lo = 0, qt = 0, id = 0, hi = 0;
default clocking @(posedge sys_clk_in); endclocking
default disable iff (!rst_b_in);
always_ff @(posedge sys_clk_in)
begin
    lo <= reset_n_out ? 16'h0 : lo + 1;
    qt <= (supply_low_in || !push_button_clear_n) ? 16'h0 : qt + 1;
    id <= (heartbeat_in != $past(heartbeat_in) || heartbeat_float_in || !reset_n_out)
        ? 16'h0 : id + 1;
    hi <= heartbeat_out ? hi + 1 : 16'h0;
end
a_inv_out: assert property (reset_out == !reset_n_out) else $error("inverse");
a_brownout_low: assert property (supply_low_in [*4] |-> !reset_n_out) else $error("brownout");
a_button_low: assert property (!push_button_clear_n [*8] ##1 !push_button_clear_n [*8] ##1
    !push_button_clear_n [*8] |-> !reset_n_out) else $error("button");
a_hold_min: assert property ($rose(reset_n_out) |-> lo >= H && qt >= H) else $error("short");
a_hold_max: assert property (!(lo == H + 40 && qt >= H + 40)) else $error("long");
a_wd_expire: assert property (id != K + 20) else $error("no expiry");
a_wd_early: assert property ($fell(reset_n_out) |-> id >= K - 10 || qt < 30) else $error("early");
a_self_kick: assert property ($fell(heartbeat_out) |-> hi == K / 8 || !reset_n_out)
    else $error("self kick");
a_oe_float: assert property (heartbeat_float_in [*4] |-> heartbeat_oe_out)
    else $error("self kick not driven");
a_oe_quiet: assert property (!heartbeat_float_in [*4] |-> !heartbeat_oe_out)
    else $error("self kick driven while pin is held");
endmodule // srw_chk
bind srw_top srw_chk #(.H(HOLD_CYC), .K(KICK_CYC)) srw_chk_i (.*);

/* File: sim/srw_cpu.sv */
`timescale 1ns/1ps
module srw_cpu
(
    input  wire logic       sys_clk_in,
    input  wire logic [1:0] mode_in,
    input  wire logic       kick_in,
    input  wire logic       oe_in,
    output logic            pin_out,
    output logic            float_out
);
// mode 0 leaves the pin open, 1 kicks, 2 is a hung program, 3 sends 50ns pulses
int n = 0;
logic lvl = 1'b0;
logic pls = 1'b0;
always @(posedge sys_clk_in)
begin
    n <= (n == 999) ? 0 : n + 1;
    if (n == 999 && mode_in == 2'h1)
        lvl <= #1 !lvl;
    pls <= #1 (mode_in == 2'h3) && (n < 5);
end
assign float_out = (mode_in == 2'h0);
// an open pin carries the internal level only while it is driven
assign pin_out = float_out ? (oe_in & kick_in) : ((mode_in == 2'h3) ? pls : lvl);
endmodule // srw_cpu

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
$display("unexpected %0t %h %h", $time, a, b); end end
module tb_top;
logic clk = 0, rst_b = 0, sl = 0, btn = 1, pin, flt, kick, oe, rn, r;
logic [1:0] mode = 1;
int err_total = 0, num_checks = 0;
// {brownout, button, cpu mode}, expected reset_n, cycles
logic [19:0] rows [19] = '{20'h5_00b4, 20'h5_103c, 20'h5_1bb8, 20'hd_000a,
    20'hd_01f4, 20'h5_00be, 20'hd_0005, 20'h5_00b4, 20'h5_103c, 20'h1_1008,
    20'h5_101e, 20'h1_001e, 20'h6_00b4, 20'h6_103c, 20'h6_15dc, 20'h6_0096,
    20'h5_10fa, 20'h7_1bb8, 20'h4_1fa0};
srw_top #(.HOLD_CYC(200), .KICK_CYC(1600), .SELF_LOW_CYC(1400)) srw_top_i (.sys_clk_in(clk),
    .rst_b_in(rst_b), .supply_low_in(sl), .push_button_clear_n(btn), .heartbeat_in(pin),
    .heartbeat_float_in(flt), .heartbeat_out(kick), .heartbeat_oe_out(oe),
    .reset_n_out(rn), .reset_out(r));
srw_cpu srw_cpu_i (.sys_clk_in(clk), .mode_in(mode), .kick_in(kick), .oe_in(oe),
    .pin_out(pin), .float_out(flt));
initial forever #5 clk = ~clk;
task step(input int n); repeat (n) @(posedge clk); #1; endtask
task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask
initial
begin
    #200000;
    err_total++;
    tally_and_finish;
end
initial
begin
    step(6);
    rst_b = 1;
    foreach (rows[i])
    begin
        {sl, btn, mode} = rows[i][19:16];
        step(rows[i][11:0]);
        `CHK(rn, rows[i][12])
        $display("row %0d", i);
    end
    `CHK(oe, 1'b1)
    rst_b = 0;
    step(2);
    `CHK({rn, r}, 2'b01)
    rst_b = 1;
    step(180);
    `CHK(rn, 1'b0)
    step(60);
    `CHK(rn, 1'b1)
    $display("reset test");
    tally_and_finish;
end
endmodule // tb_top
